//--- esd_pkg.sv
// Purpose: Shared constants and state types for the far store, widen,
//          sleep select, add one and short branch decode slice.
// Assumes: APB with 32-bit data; byte addresses on the bus.
// Notes:   Flag positions and register offsets are defined here; the bench repeats them as literals.
`default_nettype none

package esd_pkg;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_INSN     = 8'h04;
  localparam logic [7:0] REG_OPA      = 8'h08;
  localparam logic [7:0] REG_OPB      = 8'h0c;
  localparam logic [7:0] REG_DISP     = 8'h10;
  localparam logic [7:0] REG_PCNEXT   = 8'h14;
  localparam logic [7:0] REG_FLAGS    = 8'h18;
  localparam logic [7:0] REG_MODE     = 8'h1c;
  localparam logic [7:0] REG_STATUS   = 8'h20;
  localparam logic [7:0] REG_RESULT   = 8'h24;
  localparam logic [7:0] REG_TARGET   = 8'h28;
  localparam logic [7:0] REG_SADDR    = 8'h2c;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CTRL_START   = 0;
  localparam int FLG_ZERO     = 0;
  localparam int FLG_NEG      = 1;
  localparam int FLG_CARRY    = 2;
  localparam int FLG_OVF      = 3;
  localparam int FLG_TRAP     = 4;
  localparam int FLG_ROUND    = 5;
  localparam int STS_BUSY     = 0;
  localparam int STS_DONE     = 1;
  localparam int STS_TAKEN    = 2;
  localparam int STS_ADDRERR  = 3;
  localparam int STS_PASSED   = 4;
  localparam int STS_PFWAIT   = 5;

  // ---------------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------------
  localparam logic [7:0] OP_FSW_IND   = 8'h1c;
  localparam logic [7:0] OP_FSW_IDX   = 8'h1d;
  localparam logic [7:0] OP_FSB_IND   = 8'h1e;
  localparam logic [7:0] OP_FSB_IDX   = 8'h1f;
  localparam logic [7:0] OP_WIDEN_W   = 8'h06;
  localparam logic [7:0] OP_WIDEN_B   = 8'h16;
  localparam logic [7:0] OP_SLEEP     = 8'hf6;
  localparam logic [7:0] OP_ADD1_W    = 8'h07;
  localparam logic [7:0] OP_ADD1_B    = 8'h17;
  localparam logic [4:0] OP_BIT_ZERO  = 5'h06;
  localparam logic [4:0] OP_BIT_ONE   = 5'h07;
  localparam logic [7:0] OP_C_SET     = 8'hdb;
  localparam logic [7:0] OP_C_CLR     = 8'hd3;
  localparam logic [7:0] OP_Z_SET     = 8'hdf;
  localparam logic [7:0] OP_Z_CLR     = 8'hd7;
  localparam logic [7:0] OP_S_NBELOW  = 8'hd6;
  localparam logic [7:0] OP_S_BELOW   = 8'hde;
  localparam logic [7:0] OP_S_ABOVE   = 8'hd2;
  localparam logic [7:0] OP_S_NABOVE  = 8'hda;
  localparam logic [7:0] OP_U_ABOVE   = 8'hd9;
  localparam logic [7:0] OP_U_NABOVE  = 8'hd1;
  localparam logic [7:0] OP_RL_CLR    = 8'hd0;
  localparam logic [7:0] OP_OVF_CLR   = 8'hd5;
  localparam logic [7:0] OP_TRAP_CLR  = 8'hd4;

  // ---------------------------------------------------------------------
  // Sleep keys, mode codes and reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] KEY_IDLE     = 8'h01;
  localparam logic [7:0] KEY_PWRDN    = 8'h02;
  localparam logic [7:0] KEY_STBY     = 8'h03;
  localparam logic [1:0] MODE_IDLE    = 2'h0;
  localparam logic [1:0] MODE_PWRDN   = 2'h1;
  localparam logic [1:0] MODE_STBY    = 2'h2;
  localparam logic [1:0] MODE_RESET   = 2'h3;
  localparam logic [5:0] FLAGS_RST    = 6'h00;
  localparam logic [23:0] ADDR_RST    = 24'h000000;

  typedef enum logic [1:0] {
    ESD_IDLE,
    ESD_EXEC,
    ESD_PFWAIT
  } esd_state_t;

  typedef struct packed {
    esd_state_t  st;
    logic [7:0]  opcode;
    logic [7:0]  arg;
    logic [31:0] opa;
    logic [15:0] opb;
    logic [23:0] disp;
    logic [23:0] pc_next;
    logic [5:0]  flags;
    logic        mode20;
    logic [31:0] result;
    logic [23:0] target;
    logic [23:0] saddr;
    logic [15:0] sdata;
    logic        sbyte;
    logic        addr_err;
    logic        taken;
    logic        passed;
    logic        done;
    logic        store_req;
    logic        wb_req;
    logic        branch_req;
    logic        power_req;
    logic [1:0]  power_mode;
    logic        pass_req;
    logic [31:0] prdata;
  } esd_regs_t;

endpackage

`default_nettype wire

//--- esd_decode.sv
// Purpose: Executes one decoded instruction of this slice per start.
// Assumes: Software loads opcode, operands, flags, then writes start.
// Notes:   Power requests wait for the prefetch cycle to finish.
//
// Summary of operation
// - Word far store, indirect or indexed address
// - Byte far store, indirect or indexed address
// - 20-bit mode: displacement must fit signed 20
// - Widen word: upper word copies bit 15
// - Widen byte: upper byte copies bit 7
// - Sleep key selects idle, powerdown, standby, reset
// - Wait for prefetch to finish before halting
// - Word register plus one, written back
// - Byte register plus one, written back
// - Bit branches test opcode-selected byte bit
// - Taken target: next address plus sign-extended arg byte
// - Carry set and carry clear branches
// - Zero set and zero clear branches
// - Negative clear and negative set branches
// - Signed above and not above branches
// - Unsigned above and not above branches
// - Branch when round loss flag clear
// - Branch when overflow flag clear
// - Trap clear branch; set trap is cleared
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module esd_decode (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        prefetch_busy_i,
  output logic             store_req_o,
  output logic [23:0]      store_addr_o,
  output logic [15:0]      store_data_o,
  output logic             store_byte_o,
  output logic             wb_req_o,
  output logic [31:0]      wb_data_o,
  output logic             branch_req_o,
  output logic [23:0]      branch_target_o,
  output logic             power_req_o,
  output logic [1:0]       power_mode_o,
  output logic             pass_req_o,
  output logic [7:0]       pass_opcode_o
);

  // ---------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------

  // True for every short branch this slice owns.
  function automatic logic is_branch(input logic [7:0] op);
    logic hit;
    hit = (op[7:3] == esd_pkg::OP_BIT_ZERO) ||
          (op[7:3] == esd_pkg::OP_BIT_ONE);
    case (op)
      esd_pkg::OP_C_SET, esd_pkg::OP_C_CLR, esd_pkg::OP_Z_SET,
      esd_pkg::OP_Z_CLR, esd_pkg::OP_S_NBELOW, esd_pkg::OP_S_BELOW,
      esd_pkg::OP_S_ABOVE, esd_pkg::OP_S_NABOVE, esd_pkg::OP_U_ABOVE,
      esd_pkg::OP_U_NABOVE, esd_pkg::OP_RL_CLR, esd_pkg::OP_OVF_CLR,
      esd_pkg::OP_TRAP_CLR: hit = 1'b1;
      default: hit = hit;
    endcase
    return hit;
  endfunction

  // Branch condition against the flags word or the tested byte.
  function automatic logic branch_taken(input logic [7:0] op,
                                        input logic [5:0] f,
                                        input logic [7:0] bv);
    logic t;
    logic z;
    logic n;
    logic c;
    z = f[esd_pkg::FLG_ZERO];
    n = f[esd_pkg::FLG_NEG];
    c = f[esd_pkg::FLG_CARRY];
    t = 1'b0;
    if (op[7:3] == esd_pkg::OP_BIT_ZERO)
    begin
      t = !bv[op[2:0]];
    end
    else if (op[7:3] == esd_pkg::OP_BIT_ONE)
    begin
      t = bv[op[2:0]];
    end
    else
    begin
      case (op)
        esd_pkg::OP_C_SET:    t = c;
        esd_pkg::OP_C_CLR:    t = !c;
        esd_pkg::OP_Z_SET:    t = z;
        esd_pkg::OP_Z_CLR:    t = !z;
        esd_pkg::OP_S_NBELOW: t = !n;
        esd_pkg::OP_S_BELOW:  t = n;
        esd_pkg::OP_S_ABOVE:  t = !n && !z;
        esd_pkg::OP_S_NABOVE: t = n || z;
        esd_pkg::OP_U_ABOVE:  t = c && !z;
        esd_pkg::OP_U_NABOVE: t = !c || z;
        esd_pkg::OP_RL_CLR:   t = !f[esd_pkg::FLG_ROUND];
        esd_pkg::OP_OVF_CLR:  t = !f[esd_pkg::FLG_OVF];
        esd_pkg::OP_TRAP_CLR: t = !f[esd_pkg::FLG_TRAP];
        default:              t = 1'b0;
      endcase
    end
    return t;
  endfunction

  // Sleep key to mode code; every unknown key means reset.
  function automatic logic [1:0] key_mode(input logic [7:0] key);
    logic [1:0] m;
    case (key)
      esd_pkg::KEY_IDLE:  m = esd_pkg::MODE_IDLE;
      esd_pkg::KEY_PWRDN: m = esd_pkg::MODE_PWRDN;
      esd_pkg::KEY_STBY:  m = esd_pkg::MODE_STBY;
      default:            m = esd_pkg::MODE_RESET;
    endcase
    return m;
  endfunction

  // Decodes a register byte address; used only for the error response.
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= esd_pkg::REG_SADDR);
  endfunction

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  esd_pkg::esd_regs_t r;
  esd_pkg::esd_regs_t next_r;

  logic        apb_wr;
  logic        apb_rd_setup;
  logic [23:0] br_disp;
  logic [23:0] idx_addr;
  logic        disp_fits20;

  // Write takes effect in the access cycle; read data is caught in
  // setup so that the answer comes from a flip-flop with no wait state.
  assign apb_wr       = psel_i && penable_i && pwrite_i;
  assign apb_rd_setup = psel_i && !penable_i && !pwrite_i;
  assign br_disp      = {{16{r.arg[7]}}, r.arg};
  assign idx_addr     = r.opa[23:0] + r.disp;
  // A 20-bit signed value has bits 23..19 all equal.
  assign disp_fits20  = (r.disp[23:19] == 5'h00) ||
                        (r.disp[23:19] == 5'h1f);

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------

  // Execution, sleep wait, then register writes from the bus.
  always_comb
  begin
    next_r            = r;
    next_r.store_req  = 1'b0;
    next_r.wb_req     = 1'b0;
    next_r.branch_req = 1'b0;
    next_r.power_req  = 1'b0;
    next_r.pass_req   = 1'b0;
    case (r.st)
      esd_pkg::ESD_IDLE:
      begin
        next_r.st = esd_pkg::ESD_IDLE;
      end
      esd_pkg::ESD_EXEC:
      begin
        next_r.st   = esd_pkg::ESD_IDLE;
        next_r.done = 1'b1;
        if (is_branch(r.opcode))
        begin
          next_r.branch_req = 1'b1;
          next_r.taken = branch_taken(r.opcode, r.flags, r.opa[7:0]);
          // Not taken falls through to the following instruction.
          next_r.target = next_r.taken ? r.pc_next + br_disp
                                       : r.pc_next;
          if (r.opcode == esd_pkg::OP_TRAP_CLR &&
              r.flags[esd_pkg::FLG_TRAP])
          begin
            next_r.flags[esd_pkg::FLG_TRAP] = 1'b0;
          end
        end
        else
        begin
          case (r.opcode)
            esd_pkg::OP_FSW_IND, esd_pkg::OP_FSB_IND:
            begin
              next_r.saddr     = r.opa[23:0];
              next_r.sbyte     = r.opcode[1];
              next_r.sdata     = r.opcode[1] ? {8'h00, r.opb[7:0]}
                                             : r.opb;
              next_r.store_req = 1'b1;
            end
            esd_pkg::OP_FSW_IDX, esd_pkg::OP_FSB_IDX:
            begin
              next_r.saddr = idx_addr;
              next_r.sbyte = r.opcode[1];
              next_r.sdata = r.opcode[1] ? {8'h00, r.opb[7:0]} : r.opb;
              // An out-of-range displacement in 20-bit mode stores
              // nothing and is reported in status instead.
              if (r.mode20 && !disp_fits20)
              begin
                next_r.addr_err = 1'b1;
              end
              else
              begin
                next_r.store_req = 1'b1;
              end
            end
            esd_pkg::OP_WIDEN_W:
            begin
              next_r.result = {{16{r.opa[15]}}, r.opa[15:0]};
              next_r.wb_req = 1'b1;
            end
            esd_pkg::OP_WIDEN_B:
            begin
              next_r.result = {r.opa[31:16], {8{r.opa[7]}},
                               r.opa[7:0]};
              next_r.wb_req = 1'b1;
            end
            esd_pkg::OP_ADD1_W:
            begin
              next_r.result = {r.opa[31:16],
                               r.opa[15:0] + 16'h0001};
              next_r.wb_req = 1'b1;
            end
            esd_pkg::OP_ADD1_B:
            begin
              next_r.result = {r.opa[31:8],
                               r.opa[7:0] + 8'h01};
              next_r.wb_req = 1'b1;
            end
            esd_pkg::OP_SLEEP:
            begin
              next_r.power_mode = key_mode(r.arg);
              // Halting mid-prefetch would leave the bus cycle torn.
              if (prefetch_busy_i)
              begin
                next_r.st   = esd_pkg::ESD_PFWAIT;
                next_r.done = 1'b0;
              end
              else
              begin
                next_r.power_req = 1'b1;
              end
            end
            default:
            begin
              next_r.passed   = 1'b1;
              next_r.pass_req = 1'b1;
            end
          endcase
        end
      end
      esd_pkg::ESD_PFWAIT:
      begin
        if (!prefetch_busy_i)
        begin
          next_r.st        = esd_pkg::ESD_IDLE;
          next_r.power_req = 1'b1;
          next_r.done      = 1'b1;
        end
      end
      default:
      begin
        next_r.st = esd_pkg::ESD_IDLE;
      end
    endcase

    // Bus writes. A flags write lands after the trap clear, so software
    // wins a collision. Start is ignored while an instruction runs.
    if (apb_wr)
    begin
      case (paddr_i)
        esd_pkg::REG_CTRL:
        begin
          if (pwdata_i[esd_pkg::CTRL_START] &&
              r.st == esd_pkg::ESD_IDLE)
          begin
            next_r.st       = esd_pkg::ESD_EXEC;
            next_r.done     = 1'b0;
            next_r.taken    = 1'b0;
            next_r.addr_err = 1'b0;
            next_r.passed   = 1'b0;
          end
        end
        esd_pkg::REG_INSN:
        begin
          next_r.opcode = pwdata_i[7:0];
          next_r.arg    = pwdata_i[15:8];
        end
        esd_pkg::REG_OPA:    next_r.opa     = pwdata_i;
        esd_pkg::REG_OPB:    next_r.opb     = pwdata_i[15:0];
        esd_pkg::REG_DISP:   next_r.disp    = pwdata_i[23:0];
        esd_pkg::REG_PCNEXT: next_r.pc_next = pwdata_i[23:0];
        esd_pkg::REG_FLAGS:  next_r.flags   = pwdata_i[5:0];
        esd_pkg::REG_MODE:   next_r.mode20  = pwdata_i[0];
        default:             next_r.mode20  = next_r.mode20;
      endcase
    end

    // Read data is captured in the setup cycle.
    if (apb_rd_setup)
    begin
      case (paddr_i)
        esd_pkg::REG_INSN:   next_r.prdata = {16'h0000, r.arg, r.opcode};
        esd_pkg::REG_OPA:    next_r.prdata = r.opa;
        esd_pkg::REG_OPB:    next_r.prdata = {16'h0000, r.opb};
        esd_pkg::REG_DISP:   next_r.prdata = {8'h00, r.disp};
        esd_pkg::REG_PCNEXT: next_r.prdata = {8'h00, r.pc_next};
        esd_pkg::REG_FLAGS:  next_r.prdata = {26'h0000000, r.flags};
        esd_pkg::REG_MODE:   next_r.prdata = {31'h00000000, r.mode20};
        esd_pkg::REG_STATUS:
          next_r.prdata = {26'h0000000,
                           r.st == esd_pkg::ESD_PFWAIT, r.passed,
                           r.addr_err, r.taken, r.done,
                           r.st != esd_pkg::ESD_IDLE};
        esd_pkg::REG_RESULT: next_r.prdata = r.result;
        esd_pkg::REG_TARGET: next_r.prdata = {8'h00, r.target};
        esd_pkg::REG_SADDR:  next_r.prdata = {8'h00, r.saddr};
        default:             next_r.prdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------

  // The whole state resets to constants.
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r       <= '0;
      r.st    <= esd_pkg::ESD_IDLE;
      r.flags <= esd_pkg::FLAGS_RST;
      r.saddr <= esd_pkg::ADDR_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------

  // Zero wait states; unmapped addresses answer with an error.
  assign pready_o        = 1'b1;
  assign pslverr_o       = psel_i && penable_i && !addr_mapped(paddr_i);
  assign prdata_o        = r.prdata;
  assign store_req_o     = r.store_req;
  assign store_addr_o    = r.saddr;
  assign store_data_o    = r.sdata;
  assign store_byte_o    = r.sbyte;
  assign wb_req_o        = r.wb_req;
  assign wb_data_o       = r.result;
  assign branch_req_o    = r.branch_req;
  assign branch_target_o = r.target;
  assign power_req_o     = r.power_req;
  assign power_mode_o    = r.power_mode;
  assign pass_req_o      = r.pass_req;
  assign pass_opcode_o   = r.opcode;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  property p_fsw_ind;
    store_req_o && $past(r.opcode) == esd_pkg::OP_FSW_IND
      |-> store_addr_o == $past(r.opa[23:0]) && !store_byte_o;
  endproperty
  a_fsw_ind: assert property (p_fsw_ind)
    else $error("Indirect word store address wrong.");

  property p_fsb_data;
    store_req_o && store_byte_o |-> store_data_o[15:8] == 8'h00;
  endproperty
  a_fsb_data: assert property (p_fsb_data)
    else $error("Byte store carries a high byte.");

  property p_range;
    r.st == esd_pkg::ESD_EXEC && r.mode20 && !disp_fits20 &&
    (r.opcode == esd_pkg::OP_FSW_IDX ||
     r.opcode == esd_pkg::OP_FSB_IDX) |=> !store_req_o;
  endproperty
  a_range: assert property (p_range)
    else $error("Out-of-range displacement was stored.");

  property p_widen_w;
    wb_req_o && $past(r.opcode) == esd_pkg::OP_WIDEN_W
      |-> wb_data_o[31:16] == {16{$past(r.opa[15])}};
  endproperty
  a_widen_w: assert property (p_widen_w)
    else $error("Word widening has a wrong upper word.");

  property p_widen_b;
    wb_req_o && $past(r.opcode) == esd_pkg::OP_WIDEN_B
      |-> wb_data_o[15:8] == {8{$past(r.opa[7])}};
  endproperty
  a_widen_b: assert property (p_widen_b)
    else $error("Byte widening has a wrong upper byte.");

  property p_prefetch;
    power_req_o |-> !$past(prefetch_busy_i);
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("Power request while prefetch busy.");

  property p_add1_w;
    wb_req_o && $past(r.opcode) == esd_pkg::OP_ADD1_W
      |-> wb_data_o[15:0] == $past(r.opa[15:0]) + 16'h0001;
  endproperty
  a_add1_w: assert property (p_add1_w)
    else $error("Word add one result wrong.");

  property p_target;
    branch_req_o && !$past(branch_taken(r.opcode, r.flags, r.opa[7:0]))
      |-> branch_target_o == $past(r.pc_next);
  endproperty
  a_target: assert property (p_target)
    else $error("Untaken branch left the sequential path.");

  property p_trap;
    r.st == esd_pkg::ESD_EXEC && r.opcode == esd_pkg::OP_TRAP_CLR &&
    r.flags[esd_pkg::FLG_TRAP] && !apb_wr
      |=> !r.flags[esd_pkg::FLG_TRAP] && !r.taken;
  endproperty
  a_trap: assert property (p_trap)
    else $error("Trap flag not cleared or branch taken.");

  property p_pass;
    pass_req_o |-> !is_branch(pass_opcode_o) && !wb_req_o &&
                   !store_req_o;
  endproperty
  a_pass: assert property (p_pass)
    else $error("Passed opcode was executed here.");

endmodule

`default_nettype wire

//--- esd_fetch_model.sv
// Purpose: Prefetch activity of the bus controller.
// Assumes: Same clock as the decoder.
// Notes:   Busy lasts len_i cycles after each go pulse.
`timescale 1ns/1ps
`default_nettype none
module esd_fetch_model (
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  input  wire logic       go_i,
  input  wire logic [3:0] len_i,
  output logic            busy_o
);
  logic [3:0] left;
  // ----------------------------------------------------------------
  // Prefetch counter
  // ----------------------------------------------------------------
  // A cycle already in flight keeps running, so a sleep must wait.
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i)
      left <= 4'h0;
    else if (go_i)
      left <= len_i;
    else if (left != 4'h0)
      left <= left - 4'h1;
  assign busy_o = (left != 4'h0);
endmodule
`default_nettype wire

//--- esd_decode_bench.sv
// Purpose: Self-checking bench with a reference model of the slice.
// Assumes: Zero-wait APB; STATUS polled until done.
// Notes:   Every opcode runs at least twice with random operands.
`timescale 1ns/1ps
`default_nettype none
module esd_decode_bench;
  logic        mclk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pf_busy, last_err, pf_prev = 1'b0;
  logic [7:0]  paddr = 8'h00, pass_opcode_o;
  logic [31:0] pwdata = 32'h0, prdata_o, wb_data_o, rq;
  logic [23:0] store_addr_o, branch_target_o;
  logic [15:0] store_data_o;
  logic [3:0]  pf_len = 4'h0;
  logic [1:0]  power_mode_o;
  logic        pready_o, pslverr_o, store_req_o, store_byte_o, wb_req_o;
  logic        branch_req_o, power_req_o, pass_req_o;
  integer      seed = 32'hbfaa;
  int          cnt [5];
  int          n_mismatch = 0, tests_run = 0;
  always #12.5 mclk_i = ~mclk_i;
  esd_decode u_esd_decode (.mclk_i, .resetn_i, .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o, .pready_o, .pslverr_o,
    .prefetch_busy_i(pf_busy), .store_req_o, .store_addr_o, .store_data_o,
    .store_byte_o, .wb_req_o, .wb_data_o, .branch_req_o, .branch_target_o,
    .power_req_o, .power_mode_o, .pass_req_o, .pass_opcode_o);
  esd_fetch_model u_esd_fetch_model (.mclk_i, .resetn_i,
    .go_i(psel & penable & pwrite & (paddr == 8'h00)), .len_i(pf_len),
    .busy_o(pf_busy));
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Pulses are counted here, since polling cannot see one-cycle pulses.
  always @(posedge mclk_i)
  begin
    cnt[0] += int'(store_req_o === 1'b1);
    cnt[1] += int'(wb_req_o === 1'b1);
    cnt[2] += int'(branch_req_o === 1'b1);
    cnt[3] += int'(power_req_o === 1'b1);
    cnt[4] += int'(pass_req_o === 1'b1);
    if (power_req_o === 1'b1)
      chk(pf_prev, 1'b0);
    pf_prev = pf_busy;
  end
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    k = 0;
    @(posedge mclk_i);
    while (pready_o !== 1'b1 && k < 20)
    begin
      @(posedge mclk_i);
      k++;
    end
    if (pready_o !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
    q = prdata_o;
    last_err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // One instruction against the reference model
  // ----------------------------------------------------------------
  task automatic run(input logic [7:0] op, input logic [7:0] arg);
    logic [31:0] opa, opb, ev, q, mk;
    logic [23:0] disp, pcn;
    logic [5:0]  fl;
    logic [3:0]  kind;
    logic        m20, c;
    int          base [5], k;
    opa = $random(seed);
    opb = $random(seed);
    disp = 24'($random(seed));
    pcn = 24'($random(seed));
    fl = 6'($random(seed));
    m20 = 1'($random(seed));
    if (seed[0])
      disp[23:19] = {5{disp[18]}};
    pf_len <= opb[19:16];
    apb(1'b1, 8'h04, {16'h0, arg, op}, q);
    apb(1'b1, 8'h08, opa, q);
    apb(1'b1, 8'h0c, opb, q);
    apb(1'b1, 8'h10, {8'h0, disp}, q);
    apb(1'b1, 8'h14, {8'h0, pcn}, q);
    apb(1'b1, 8'h18, {26'h0, fl}, q);
    apb(1'b1, 8'h1c, {31'h0, m20}, q);
    base = cnt;
    apb(1'b1, 8'h00, 32'h1, q);
    k = 0;
    q = 32'h1;
    while (q[1:0] !== 2'b10 && k < 40)
    begin
      apb(1'b0, 8'h20, 32'h0, q);
      k++;
    end
    if (q[1:0] !== 2'b10)
    begin
      n_mismatch++;
      finish_test();
    end
    {kind, ev, c} = {4'd4, 24'h0, op, 1'b0};
    mk = (op == 8'h06) ? 32'hffffffff : (op == 8'h17) ? 32'hff : 32'hffff;
    case (op) inside
      [8'h1c:8'h1f]: {kind, ev} = {4'd0, 8'h0, opa[23:0] + (op[0] ? disp : 24'h0)};
      8'h06: {kind, ev} = {4'd1, {16{opa[15]}}, opa[15:0]};
      8'h16: {kind, ev} = {4'd1, 16'h0, {8{opa[7]}}, opa[7:0]};
      8'h07: {kind, ev} = {4'd1, 16'h0, opa[15:0] + 16'h1};
      8'h17: {kind, ev} = {4'd1, 24'h0, opa[7:0] + 8'h1};
      8'hf6: {kind, ev} = {4'd3, 30'h0, arg == 8'h1 ? 2'h0 : arg == 8'h2 ? 2'h1 : arg == 8'h3 ? 2'h2 : 2'h3};
      [8'h30:8'h3f]: c = (opa[op[2:0]] == op[3]);
      8'hdb: c = fl[2];
      8'hd3: c = !fl[2];
      8'hdf: c = fl[0];
      8'hd7: c = !fl[0];
      8'hd6: c = !fl[1];
      8'hde: c = fl[1];
      8'hd2: c = !fl[1] && !fl[0];
      8'hda: c = fl[1] || fl[0];
      8'hd9: c = fl[2] && !fl[0];
      8'hd1: c = !fl[2] || fl[0];
      8'hd0: c = !fl[5];
      8'hd5: c = !fl[3];
      8'hd4: c = !fl[4];
      default: ;
    endcase
    if (op inside {[8'h30:8'h3f], [8'hd0:8'hd7], [8'hd9:8'hdb], [8'hde:8'hdf]})
      {kind, ev} = {4'd2, 8'h0, c ? pcn + {{16{arg[7]}}, arg} : pcn};
    if (kind == 0 && op[0] && m20 && disp[23:19] != 5'h00 && disp[23:19] != 5'h1f)
      kind = 4'd5;
    for (int i = 0; i < 5; i++)
      chk(cnt[i] - base[i], kind == i);
    chk(q[3], kind == 5);
    if (kind == 0)
      chk({store_byte_o, store_data_o}, {op[1], op[1] ? {8'h0, opb[7:0]} : opb[15:0]});
    if (kind == 0)
      chk(store_addr_o, ev);
    if (kind == 1)
      chk(wb_data_o & mk, ev & mk);
    if (kind == 2)
      chk(branch_target_o, ev);
    if (kind == 3)
      chk(power_mode_o, ev);
    if (kind == 4)
      chk(pass_opcode_o, ev);
    apb(1'b0, 8'h18, 32'h0, q);
    chk(q[5:0], (op == 8'hd4) ? fl & 6'h2f : fl);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int p = 0; p < 512; p++)
      run(p[7:0], 8'($random(seed)));
    for (int k = 0; k < 5; k++)
      run(8'hf6, k[7:0]);
    apb(1'b0, 8'h30, 32'h0, rq);
    chk({rq[30:0], last_err}, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
